// >>> dv/tape_drive_model.sv
// Behavioural drive mechanism: capstan and cartridge latch of four drives.
// Assumes the drive lines come straight from the select block, sampled on clk_i.
`timescale 1ns/1ps
module tape_drive_model (
  // Clock
  input  wire logic       clk_i,
  // Drive lines from the controller
  input  wire logic [3:0] hold_i,
  input  wire logic [3:0] go_i,
  input  wire logic       reverse_i,
  input  wire logic       high_speed_i,
  // Mechanism state
  output logic [3:0]      locked_o,
  output logic            fast_o
);
  logic [15:0] pos_r;  // Tape position of the running drive

  // Latch, speed and position; speed is only taken while stopped,
  // so a change in speed is ignored until go drops
  always_ff @(posedge clk_i)
  begin
    locked_o <= hold_i;
    if (go_i == 4'h0)
      fast_o <= high_speed_i;
    if (go_i != 4'h0)
      pos_r <= reverse_i ? pos_r - 16'h0001 : pos_r + 16'h0001;
  end
endmodule

// >>> dv/test_tape_drive_select_control.sv
// Self-checking bench: Wishbone register tasks and datapath event sequences.
// Assumes tape_sel_pkg and the drive model; clock 50 ns, sync reset.
`timescale 1ns/1ps
module test_tape_drive_select_control;
  // Bench signals, named as the ports they drive or watch
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0]  adr_i, op_cmd_i, op_status_i, blk_id_i, blk_buf_i, rewrite_buf_o, rewrite_blk_o;
  logic [3:0]  sel_i, track_number_o, drive_select_o, cartridge_hold_o;
  logic [3:0]  write_current_o, erase_current_o, capstan_go_o, locked;
  logic [31:0] dat_i, dat_o, rd;
  logic        op_start_i, op_write_i, retry_i, bad_record_i, rewrite_req_i, blk_valid_i;
  logic        reverse_o, high_speed_o, rewrite_active_o, hard_error_o, irq_o, fast;
  int          failures, n_tests;

  tape_drive_select_control i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .op_start_i, .op_write_i, .op_cmd_i, .op_status_i, .retry_i, .bad_record_i,
    .rewrite_req_i, .blk_valid_i, .blk_id_i, .blk_buf_i, .track_number_o, .drive_select_o,
    .cartridge_hold_o, .write_current_o, .erase_current_o, .reverse_o, .capstan_go_o, .high_speed_o,
    .rewrite_buf_o, .rewrite_blk_o, .rewrite_active_o, .hard_error_o, .irq_o);
  tape_drive_model i_drv (.clk_i(clk_i), .hold_i(cartridge_hold_o), .go_i(capstan_go_o),
    .reverse_i(reverse_o), .high_speed_i(high_speed_o), .locked_o(locked), .fast_o(fast));

  // Free-running clock, 50 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; held until ack is sampled, read data taken at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Let the ack edge's updates land before looking at outputs
  task automatic settle;
    @(negedge clk_i);
  endtask

  task automatic op(input logic w, input logic [7:0] cmd, input logic [7:0] st);
    @(posedge clk_i);
    op_start_i  <= 1'b1;
    op_write_i  <= w;
    op_cmd_i    <= cmd;
    op_status_i <= st;
    @(posedge clk_i);
    op_start_i  <= 1'b0;
  endtask

  task automatic blk(input logic [7:0] id, input logic [7:0] b);
    @(posedge clk_i);
    blk_valid_i <= 1'b1;
    blk_id_i    <= id;
    blk_buf_i   <= b;
    @(posedge clk_i);
    blk_valid_i <= 1'b0;
  endtask

  task automatic end_sim;
    $display("Compares %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard; the whole sequence needs well under 40 us
  initial
  begin
    #400_000;
    failures++;
    end_sim();
  end

  initial
  begin
    {cyc_i, stb_i, we_i, op_start_i, op_write_i, retry_i, bad_record_i, rewrite_req_i, blk_valid_i} = '0;
    {adr_i, op_cmd_i, op_status_i, blk_id_i, blk_buf_i, dat_i} = '0;
    sel_i = 4'hF;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // Pick and motion registers drive the lines
    rdc(tape_sel_pkg::OFF_TRACK_LIMIT, 8'hF0);
    bus(1'b1, tape_sel_pkg::OFF_TRACK_PICK, 32'h0000_005A);
    rdc(tape_sel_pkg::OFF_TRACK_PICK, 8'h52);
    bus(1'b1, tape_sel_pkg::OFF_MOTION, 32'h0000_00F8);
    settle();
    chk(track_number_o, 4'h5);
    chk(drive_select_o, 4'h2);
    chk(cartridge_hold_o, 4'hF);
    chk(write_current_o, 4'h2);
    chk(erase_current_o, 4'h0);
    chk(reverse_o, 1'b1);
    chk(capstan_go_o, 4'h2);
    bus(1'b1, tape_sel_pkg::OFF_TRACK_PICK, 32'h0000_0001);
    chk(locked, 4'hF);
    bus(1'b1, tape_sel_pkg::OFF_MOTION, 32'h0000_0024);
    settle();
    chk(erase_current_o, 4'h1);
    chk({write_current_o, capstan_go_o}, 8'h00);
    chk(reverse_o, 1'b0);
    bus(1'b1, tape_sel_pkg::OFF_MOTION, 32'h0000_000C);
    settle();
    chk(fast, 1'b1);
    bus(1'b1, tape_sel_pkg::OFF_MOTION, 32'h0000_0008);
    settle();
    chk(fast, 1'b1);
    $display("Test drive lines done");
    // Track limit overrun raises a maskable, clearable interrupt
    bus(1'b1, tape_sel_pkg::OFF_TRACK_LIMIT, 32'h0000_00F6);
    bus(1'b1, tape_sel_pkg::OFF_IRQ_ENABLE, 32'h0000_0008);
    bus(1'b1, tape_sel_pkg::OFF_TRACK_PICK, 32'h0000_0091);
    rdc(tape_sel_pkg::OFF_IRQ_STATUS, 8'h00);
    bus(1'b1, tape_sel_pkg::OFF_TRACK_PICK, 32'h0000_00A1);
    rdc(tape_sel_pkg::OFF_IRQ_STATUS, 8'h08);
    rdc(tape_sel_pkg::OFF_FLAGS, 8'h08);
    chk(irq_o, 1'b1);
    bus(1'b1, tape_sel_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
    settle();
    chk(irq_o, 1'b0);
    bus(1'b1, tape_sel_pkg::OFF_IRQ_CLEAR, 32'h0000_0008);
    rdc(tape_sel_pkg::OFF_IRQ_STATUS, 8'h00);
    rdc(8'h50, 8'h00);
    $display("Test overrun done");
    // Retry and bad record counts, command history
    op(1'b1, 8'h3C, 8'hA5);
    retry_i <= 1'b1;
    repeat (15) @(posedge clk_i);
    retry_i <= 1'b0;
    settle();
    chk(hard_error_o, 1'b0);
    op(1'b1, 8'h3C, 8'hA5);
    retry_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    retry_i <= 1'b0;
    bad_record_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    bad_record_i <= 1'b0;
    rdc(tape_sel_pkg::OFF_COUNTS, 16'h0310);
    chk(hard_error_o, 1'b1);
    rdc(tape_sel_pkg::OFF_LAST_CMD, 8'h3C);
    rdc(tape_sel_pkg::OFF_IRQ_STATUS, 8'h11);
    rdc(tape_sel_pkg::OFF_FLAGS, 8'h0E);
    op(1'b1, 8'h41, 8'h5A);
    rdc(tape_sel_pkg::OFF_COUNTS, 16'h0000);
    rdc(tape_sel_pkg::OFF_HIST_LO, 24'hA5_A55A);
    $display("Test counts done");
    // Block tracking and rewrite bookkeeping during a write, then block tracking during a read
    bus(1'b1, tape_sel_pkg::OFF_EXP_BLK, 32'h0000_0007);
    bus(1'b1, tape_sel_pkg::OFF_VERIFY_NEXT, 32'h0000_0003);
    bus(1'b1, tape_sel_pkg::OFF_RW_BUF, 32'h0000_0011);
    bus(1'b1, tape_sel_pkg::OFF_RW_BLK, 32'h0000_0022);
    bus(1'b1, tape_sel_pkg::OFF_RB_BUF, 32'h0000_0004);
    settle();
    chk({rewrite_buf_o, rewrite_blk_o}, 16'h1122);
    @(posedge clk_i);
    rewrite_req_i <= 1'b1;
    @(posedge clk_i);
    rewrite_req_i <= 1'b0;
    blk(8'h07, 8'h02);
    rdc(tape_sel_pkg::OFF_EXP_BLK, 8'h08);
    rdc(tape_sel_pkg::OFF_VERIFY_NEXT, 8'h04);
    rdc(tape_sel_pkg::OFF_ORIGIN, 8'h04);
    chk(rewrite_active_o, 1'b1);
    blk(8'h09, 8'h04);
    rdc(tape_sel_pkg::OFF_EXP_BLK, 8'h08);
    chk(rewrite_active_o, 1'b1);
    blk(8'h08, 8'h04);
    settle();
    chk(rewrite_active_o, 1'b0);
    op(1'b0, 8'h21, 8'h00);
    blk(8'h09, 8'h01);
    rdc(tape_sel_pkg::OFF_VERIFY_NEXT, 8'h05);
    rdc(tape_sel_pkg::OFF_EXP_BLK, 8'h0A);
    rdc(tape_sel_pkg::OFF_IRQ_STATUS, 8'h17);
    $display("Test blocks done");
    end_sim();
  end
endmodule

// >>> hdl/tape_drive_select_control.sv
// Drive select, motion control and rewrite/retry bookkeeping for a cartridge tape controller.
// Assumes a classic Wishbone master, synchronous inputs on clk_i, and a datapath giving one-cycle event pulses.
`timescale 1ns/1ps

module tape_drive_select_control #(
  parameter int DRIVES = 4  // Radially selected drives
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Operation events from the read/write datapath
  input  wire logic              op_start_i,
  input  wire logic              op_write_i,
  input  wire logic [7:0]        op_cmd_i,
  input  wire logic [7:0]        op_status_i,
  input  wire logic              retry_i,
  input  wire logic              bad_record_i,
  input  wire logic              rewrite_req_i,
  input  wire logic              blk_valid_i,
  input  wire logic [7:0]        blk_id_i,
  input  wire logic [7:0]        blk_buf_i,
  // Drive lines
  output logic [3:0]             track_number_o,
  output logic [DRIVES-1:0]      drive_select_o,
  output logic [DRIVES-1:0]      cartridge_hold_o,
  output logic [DRIVES-1:0]      write_current_o,
  output logic [DRIVES-1:0]      erase_current_o,
  output logic                   reverse_o,
  output logic [DRIVES-1:0]      capstan_go_o,
  output logic                   high_speed_o,
  // Bookkeeping results
  output logic [7:0]             rewrite_buf_o,
  output logic [7:0]             rewrite_blk_o,
  output logic                   rewrite_active_o,
  output logic                   hard_error_o,
  output logic                   irq_o
);

  localparam int HIST_BYTES = tape_sel_pkg::HIST_BYTES;  // Old status depth, needed by the array below

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]                     pick_r;        // Track and drive pick
  logic [7:0]                     motion_r;      // Motion control
  logic [7:0]                     limit_r;       // Track limit
  logic [7:0]                     verify_r;      // verify_next_block
  logic [7:0]                     rw_buf_r;      // rewrite_buffer_ptr
  logic [7:0]                     rw_blk_r;      // rewrite_block_ptr
  logic [7:0]                     rb_buf_r;      // readback_buffer_now
  logic [7:0]                     exp_blk_r;     // expected_block_id
  logic [7:0]                     origin_r;      // rewrite_origin_buffer
  logic [7:0]                     last_cmd_r;    // Last command executed
  logic [7:0]                     hist_r [HIST_BYTES];  // Old status bytes
  logic [4:0]                     retry_r;       // compound_retry_count
  logic [7:0]                     bad_r;         // Bad records this operation
  logic                           op_write_r;    // Current operation is a write
  logic                           rewrite_r;     // Rewrite in progress
  logic [tape_sel_pkg::EV_W-1:0]  ev_stat_r;     // Sticky events
  logic [tape_sel_pkg::EV_W-1:0]  ev_en_r;       // Event enables
  logic                           ack_r;         // Bus acknowledge
  logic [31:0]                    dat_r;         // Read data

  // ****************************************
  // Bus decode
  // ****************************************
  logic       bus_req;      // Request waiting for its ack
  logic       wr_now;       // Write takes effect at this edge
  logic [7:0] wbyte;        // Low byte of write data
  logic       tk_overrun;   // Selected track beyond limit
  logic [8:0] tk_sum;       // Track plus limit, with carry
  logic       blk_match;    // Arriving block is the expected one
  logic       retry_hit;    // This retry reaches the limit
  logic [tape_sel_pkg::EV_W-1:0] ev_now;  // Events this cycle

  assign bus_req = cyc_i && stb_i && !ack_r;
  // Writes land on the edge where the master sees ack, never earlier
  assign wr_now  = cyc_i && stb_i && we_i && ack_r && sel_i[0];
  assign wbyte   = dat_i[7:0];

  // Adding the limit carries out exactly when track > highest allowed
  assign tk_sum     = {1'b0, 4'h0, pick_r[tape_sel_pkg::TRACK_HI:tape_sel_pkg::TRACK_LO]} + {1'b0, limit_r};
  assign tk_overrun = tk_sum[8];
  assign blk_match  = (blk_id_i == exp_blk_r);
  assign retry_hit  = retry_i && !op_start_i && (retry_r == tape_sel_pkg::RETRY_LIMIT - 5'h01);

  // Bus acknowledge, one wait state, dropped the cycle after it is given
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req;
  end
  assign ack_o = ack_r;

  // Read mux, registered so data stands with ack; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_r <= 32'h0000_0000;
    else if (bus_req)
    begin
      unique case (adr_i)
        tape_sel_pkg::OFF_TRACK_PICK:  dat_r <= {24'h00_0000, pick_r};
        tape_sel_pkg::OFF_MOTION:      dat_r <= {24'h00_0000, motion_r};
        tape_sel_pkg::OFF_TRACK_LIMIT: dat_r <= {24'h00_0000, limit_r};
        tape_sel_pkg::OFF_VERIFY_NEXT: dat_r <= {24'h00_0000, verify_r};
        tape_sel_pkg::OFF_RW_BUF:      dat_r <= {24'h00_0000, rw_buf_r};
        tape_sel_pkg::OFF_RW_BLK:      dat_r <= {24'h00_0000, rw_blk_r};
        tape_sel_pkg::OFF_RB_BUF:      dat_r <= {24'h00_0000, rb_buf_r};
        tape_sel_pkg::OFF_EXP_BLK:     dat_r <= {24'h00_0000, exp_blk_r};
        tape_sel_pkg::OFF_ORIGIN:      dat_r <= {24'h00_0000, origin_r};
        tape_sel_pkg::OFF_LAST_CMD:    dat_r <= {24'h00_0000, last_cmd_r};
        tape_sel_pkg::OFF_HIST_LO:     dat_r <= {hist_r[3], hist_r[2], hist_r[1], hist_r[0]};
        tape_sel_pkg::OFF_HIST_HI:     dat_r <= {16'h0000, hist_r[5], hist_r[4]};
        tape_sel_pkg::OFF_COUNTS:      dat_r <= {16'h0000, bad_r, 3'b000, retry_r};
        tape_sel_pkg::OFF_IRQ_STATUS:  dat_r <= {27'h000_0000, ev_stat_r};
        tape_sel_pkg::OFF_IRQ_ENABLE:  dat_r <= {27'h000_0000, ev_en_r};
        tape_sel_pkg::OFF_FLAGS:       dat_r <= {28'h000_0000, tk_overrun, hard_error_o, op_write_r, rewrite_r};
        default:                       dat_r <= 32'h0000_0000;
      endcase
    end
  end
  assign dat_o = dat_r;

  // ****************************************
  // Drive select and motion
  // ****************************************
  // Pick register; a select write with several bits keeps only the lowest one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pick_r <= tape_sel_pkg::BYTE_RST;
    else if (wr_now && adr_i == tape_sel_pkg::OFF_TRACK_PICK)
    begin
      pick_r[tape_sel_pkg::TRACK_HI:tape_sel_pkg::TRACK_LO] <= wbyte[7:4];
      pick_r[tape_sel_pkg::SEL_HI:0] <= wbyte[3:0] & (~wbyte[3:0] + 4'h1);
    end
  end

  // Motion control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      motion_r <= tape_sel_pkg::BYTE_RST;
    else if (wr_now && adr_i == tape_sel_pkg::OFF_MOTION)
      motion_r <= wbyte;
  end

  // Drive lines; the erase gate protects data on any track but zero
  assign track_number_o = pick_r[tape_sel_pkg::TRACK_HI:tape_sel_pkg::TRACK_LO];
  assign drive_select_o = pick_r[DRIVES-1:0];
  assign reverse_o      = motion_r[tape_sel_pkg::MC_REVERSE];
  assign high_speed_o   = motion_r[tape_sel_pkg::MC_HIGH_SPEED];  // Software must drop go first

  genvar gd;
  generate
    for (gd = 0; gd < DRIVES; gd++)
    begin : g_drive
      assign cartridge_hold_o[gd] = motion_r[tape_sel_pkg::MC_HOLD];
      assign write_current_o[gd]  = motion_r[tape_sel_pkg::MC_WRITE] && pick_r[gd];
      assign erase_current_o[gd]  = motion_r[tape_sel_pkg::MC_ERASE] && pick_r[gd] && track_number_o == 4'h0;
      assign capstan_go_o[gd]     = motion_r[tape_sel_pkg::MC_GO] && pick_r[gd];
    end
  endgenerate

  // ****************************************
  // Pointers
  // ****************************************
  // Track limit, software written
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      limit_r <= tape_sel_pkg::TRACK_LIMIT_RST;
    else if (wr_now && adr_i == tape_sel_pkg::OFF_TRACK_LIMIT)
      limit_r <= wbyte;
  end

  // Rewrite pointers feed the write logic directly
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rw_buf_r <= tape_sel_pkg::BYTE_RST;
      rw_blk_r <= tape_sel_pkg::BYTE_RST;
      rb_buf_r <= tape_sel_pkg::BYTE_RST;
    end
    else if (wr_now)
    begin
      if (adr_i == tape_sel_pkg::OFF_RW_BUF)
        rw_buf_r <= wbyte;
      if (adr_i == tape_sel_pkg::OFF_RW_BLK)
        rw_blk_r <= wbyte;
      if (adr_i == tape_sel_pkg::OFF_RB_BUF)
        rb_buf_r <= wbyte;
    end
  end
  assign rewrite_buf_o = rw_buf_r;
  assign rewrite_blk_o = rw_blk_r;

  // Expected block advances on a match; a mismatch leaves it for the retry
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      exp_blk_r <= tape_sel_pkg::BYTE_RST;
    else if (blk_valid_i && blk_match)
      exp_blk_r <= exp_blk_r + 8'h01;
    else if (wr_now && adr_i == tape_sel_pkg::OFF_EXP_BLK)
      exp_blk_r <= wbyte;
  end

  // Verify pointer advances on a block match only while a write operation is running; a bus write loads it unless an advance falls in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      verify_r <= tape_sel_pkg::BYTE_RST;
    else if (blk_valid_i && blk_match && op_write_r)
      verify_r <= verify_r + 8'h01;
    else if (wr_now && adr_i == tape_sel_pkg::OFF_VERIFY_NEXT)
      verify_r <= wbyte;
  end

  // Rewrite flag; a new request wins over a read-back in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rewrite_r <= 1'b0;
      origin_r  <= tape_sel_pkg::BYTE_RST;
    end
    else if (rewrite_req_i)
    begin
      rewrite_r <= 1'b1;
      origin_r  <= rb_buf_r;
    end
    else if (rewrite_r && blk_valid_i && blk_match && blk_buf_i == origin_r)
      rewrite_r <= 1'b0;
  end
  assign rewrite_active_o = rewrite_r;

  // ****************************************
  // Operation history and counts
  // ****************************************
  // Operation start records command and shifts in the status byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      last_cmd_r <= tape_sel_pkg::BYTE_RST;
      op_write_r <= 1'b0;
      for (int i = 0; i < HIST_BYTES; i++)
        hist_r[i] <= tape_sel_pkg::BYTE_RST;
    end
    else if (op_start_i)
    begin
      last_cmd_r <= op_cmd_i;
      op_write_r <= op_write_i;
      hist_r[0]  <= op_status_i;
      for (int i = 1; i < HIST_BYTES; i++)
        hist_r[i] <= hist_r[i-1];
    end
  end

  // Retry counter saturates at the limit, which is the hard error
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      retry_r <= 5'h00;
    else if (op_start_i)
      retry_r <= 5'h00;
    else if (retry_i && retry_r != tape_sel_pkg::RETRY_LIMIT)
      retry_r <= retry_r + 5'h01;
  end
  assign hard_error_o = (retry_r == tape_sel_pkg::RETRY_LIMIT);

  // Bad records, saturating so a long bad stretch never wraps to zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bad_r <= tape_sel_pkg::BYTE_RST;
    else if (op_start_i)
      bad_r <= tape_sel_pkg::BYTE_RST;
    else if (bad_record_i && bad_r != 8'hFF)
      bad_r <= bad_r + 8'h01;
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always_comb
  begin
    ev_now = '0;
    ev_now[tape_sel_pkg::EV_HARD_ERROR]   = retry_hit;
    ev_now[tape_sel_pkg::EV_BLK_MISMATCH] = blk_valid_i && !blk_match;
    ev_now[tape_sel_pkg::EV_REWRITE_DONE] = rewrite_r && !rewrite_req_i && blk_valid_i && blk_match
                                            && blk_buf_i == origin_r;
    ev_now[tape_sel_pkg::EV_TRK_OVERRUN]  = wr_now && adr_i == tape_sel_pkg::OFF_TRACK_PICK
                                            && ({4'h0, wbyte[7:4]} + limit_r) < {4'h0, wbyte[7:4]};
    ev_now[tape_sel_pkg::EV_BAD_RECORD]   = bad_record_i;
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ev_stat_r <= '0;
    else if (wr_now && adr_i == tape_sel_pkg::OFF_IRQ_CLEAR)
      ev_stat_r <= (ev_stat_r & ~dat_i[tape_sel_pkg::EV_W-1:0]) | ev_now;
    else
      ev_stat_r <= ev_stat_r | ev_now;
  end

  // Interrupt enables
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ev_en_r <= '0;
    else if (wr_now && adr_i == tape_sel_pkg::OFF_IRQ_ENABLE)
      ev_en_r <= dat_i[tape_sel_pkg::EV_W-1:0];
  end
  assign irq_o = |(ev_stat_r & ev_en_r);

  // ****************************************
  // Checks
  // ****************************************
  pick_onehot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(drive_select_o)) else $error("more than one drive selected");

  track_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_now && adr_i == tape_sel_pkg::OFF_TRACK_PICK |=> track_number_o == $past(dat_i[7:4]))
    else $error("track number not taken from write");

  erase_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|erase_current_o) |-> track_number_o == 4'h0 && motion_r[tape_sel_pkg::MC_ERASE])
    else $error("erase current off track zero");

  hold_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
    motion_r[tape_sel_pkg::MC_HOLD] |-> &cartridge_hold_o) else $error("hold not on all drives");

  go_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    capstan_go_o == (drive_select_o & {DRIVES{motion_r[tape_sel_pkg::MC_GO]}}) &&
    write_current_o == (drive_select_o & {DRIVES{motion_r[tape_sel_pkg::MC_WRITE]}}))
    else $error("go or write current not on selected drive");

  retry_hard_a: assert property (@(posedge clk_i) disable iff (rst_i)
    retry_hit |=> hard_error_o && ev_stat_r[tape_sel_pkg::EV_HARD_ERROR])
    else $error("sixteenth retry gave no hard error");

  op_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    op_start_i |=> retry_r == 5'h00 && bad_r == 8'h00 && last_cmd_r == $past(op_cmd_i))
    else $error("operation start did not clear counts");

  verify_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !op_write_r && !wr_now |=> $stable(verify_r)) else $error("verify pointer moved on read");

  rewrite_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rewrite_req_i ##1 !(blk_valid_i && blk_match && blk_buf_i == origin_r) [*2] |-> rewrite_r)
    else $error("rewrite flag dropped early");

  block_adv_a: assert property (@(posedge clk_i) disable iff (rst_i)
    blk_valid_i && blk_match |=> exp_blk_r == $past(exp_blk_r) + 8'h01)
    else $error("expected block did not advance");

  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held two cycles");

endmodule

// >>> hdl/tape_sel_pkg.sv
// Package for the tape drive select and bookkeeping block.
// Assumes a 32-bit classic Wishbone register bus with word-aligned byte addresses.
package tape_sel_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_TRACK_PICK   = 8'h00;  // drive_track_pick
  localparam logic [7:0] OFF_MOTION       = 8'h04;  // drive_motion_control
  localparam logic [7:0] OFF_TRACK_LIMIT  = 8'h08;  // Two's complement track limit
  localparam logic [7:0] OFF_VERIFY_NEXT  = 8'h0C;  // verify_next_block
  localparam logic [7:0] OFF_RW_BUF       = 8'h10;  // rewrite_buffer_ptr
  localparam logic [7:0] OFF_RW_BLK       = 8'h14;  // rewrite_block_ptr
  localparam logic [7:0] OFF_RB_BUF       = 8'h18;  // readback_buffer_now
  localparam logic [7:0] OFF_EXP_BLK      = 8'h1C;  // expected_block_id
  localparam logic [7:0] OFF_ORIGIN       = 8'h20;  // rewrite_origin_buffer, read only
  localparam logic [7:0] OFF_LAST_CMD     = 8'h24;  // Last command code, read only
  localparam logic [7:0] OFF_HIST_LO      = 8'h28;  // Old status bytes 0..3
  localparam logic [7:0] OFF_HIST_HI      = 8'h2C;  // Old status bytes 4..5
  localparam logic [7:0] OFF_COUNTS       = 8'h30;  // Retry count and bad record count
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h34;  // Sticky events, read only
  localparam logic [7:0] OFF_IRQ_CLEAR    = 8'h38;  // Write one to clear, write only
  localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h3C;  // Interrupt enables
  localparam logic [7:0] OFF_FLAGS        = 8'h40;  // Live flags, read only

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TRACK_HI        = 7;  // Track number, MSB
  localparam int TRACK_LO        = 4;  // Track number, LSB
  localparam int SEL_HI          = 3;  // Radial select, drive 3
  localparam int MC_HOLD         = 7;  // cartridge_hold
  localparam int MC_WRITE        = 6;  // Write current
  localparam int MC_ERASE        = 5;  // Erase current
  localparam int MC_REVERSE      = 4;  // Direction, set = finish toward start
  localparam int MC_GO           = 3;  // Capstan go
  localparam int MC_HIGH_SPEED   = 2;  // High speed request
  localparam int EV_HARD_ERROR   = 0;  // Retry count reached limit
  localparam int EV_BLK_MISMATCH = 1;  // Arriving block not the expected one
  localparam int EV_REWRITE_DONE = 2;  // Origin buffer read back
  localparam int EV_TRK_OVERRUN  = 3;  // Track past the limit
  localparam int EV_BAD_RECORD   = 4;  // Bad record counted
  localparam int EV_W            = 5;  // Event vector width

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] TRACK_FIELD_MASK = 8'hF0;  // track_field_mask
  localparam logic [7:0] TRACK_LIMIT_RST  = 8'hF0;  // -(15 + 1), all sixteen tracks allowed
  localparam logic [7:0] BYTE_RST         = 8'h00;  // Plain byte reset value
  localparam logic [4:0] RETRY_LIMIT      = 5'h10;  // Retries that make a hard error
  localparam int         HIST_BYTES       = 6;      // Old status bytes kept

endpackage
